// File: pkg/rsc_pkg.sv
// constants shared by the reset source combiner: register map, field
// positions, reset values and timing.
// assumes a 25 MHz system clock and a 32-bit classic Wishbone slave port.
package rsc_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0]  RSC_ADR_CAUSE    = 8'h00; // reset_cause_status
   localparam logic [7:0]  RSC_ADR_IRQMASK  = 8'h04; // interrupt mask
   localparam logic [7:0]  RSC_ADR_IRQSTAT  = 8'h08; // interrupt status, w1c
   localparam int          RSC_ADR_W        = 8;

   // ----------------------------------------------------------------
   // reset source / flag bit positions
   // ----------------------------------------------------------------
   localparam int          RSC_NSRC         = 8;
   localparam int          RSC_BIT_POR      = 0;  // power-on flag
   localparam int          RSC_BIT_BOR      = 1;  // brown_out_flag
   localparam int          RSC_BIT_EXT      = 2;  // external_clear_pin flag
   localparam int          RSC_BIT_SW       = 3;  // software_reset_flag
   localparam int          RSC_BIT_WDT      = 4;  // watchdog_timeout_flag
   localparam int          RSC_BIT_CM       = 5;  // config_mismatch_flag
   localparam int          RSC_BIT_TRAP     = 6;  // trap_conflict_flag
   localparam int          RSC_BIT_ILL      = 7;  // illegal_condition_flag
   localparam int          RSC_BIT_SWDT     = 8;  // soft_watchdog_enable
   localparam int          RSC_CAUSE_W      = 16;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [15:0] RSC_CAUSE_POR    = 16'h0001; // only the power-on flag
   localparam logic [7:0]  RSC_MASK_RST     = 8'h00;
   localparam logic [2:0]  RSC_SYNC_INIT    = 3'h4;     // ext clear pin idles high

   // ----------------------------------------------------------------
   // timing: least hold of the master reset after the last source ends
   // ----------------------------------------------------------------
   localparam int          RSC_CLK_NS       = 40;
   localparam int          RSC_HOLD_NS      = 1000;
   localparam int          RSC_HOLD_CYC     = (RSC_HOLD_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
   localparam int          RSC_HOLD_W       = $clog2(RSC_HOLD_CYC + 1);
   localparam logic [1:0]  RSC_STRAP_CYC    = 2'h3; // strap samples after nrst, last one valid

endpackage

// File: src/reset_source_combiner.sv
// reset source combiner: merges all reset sources into one master system
// reset, records the cause in a status register and raises an interrupt.
// assumes power-on, brown-out, pin and strap inputs are asynchronous;
// the remaining sources come from logic on clk. registers are reached
// over a 32-bit classic Wishbone slave.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module reset_source_combiner
   import rsc_pkg::*;
#(
   parameter int HOLD_CYC = RSC_HOLD_CYC
) (
   input  wire logic        clk,                // system clock, 25 MHz
   input  wire logic        nrst,               // synchronous reset, active low
   input  wire logic        powerOnReq,         // power-on detector, async
   input  wire logic        brownOutReq,        // brown-out detector, async
   input  wire logic        externalClearPinN,  // external clear pin, async, low active
   input  wire logic        softwareResetReq,   // reset instruction executed
   input  wire logic        watchdogTimeoutReq, // watchdog timed out
   input  wire logic        configMismatchReq,  // configuration mismatch
   input  wire logic        trapConflictReq,    // trap conflict
   input  wire logic        illegalCondReq,     // illegal opcode / W reg / security
   input  wire logic        nvWatchdogEnable,   // nonvolatile strap, async
   input  wire logic        cyc_i,              // wishbone cycle
   input  wire logic        stb_i,              // wishbone strobe
   input  wire logic        we_i,               // wishbone write enable
   input  wire logic [7:0]  adr_i,              // wishbone byte address
   input  wire logic [31:0] dat_i,              // wishbone write data
   input  wire logic [3:0]  sel_i,              // wishbone byte select
   output logic      [31:0] dat_o,              // wishbone read data
   output logic             ack_o,              // wishbone acknowledge
   output logic             masterSystemReset,  // master reset, high active
   output logic             watchdogEnable,     // watchdog run enable
   output logic             irq                 // level interrupt
);

   typedef struct packed {
      logic [RSC_CAUSE_W-1:0] cause;
      logic [RSC_NSRC-1:0]    irqStat;
      logic [RSC_NSRC-1:0]    irqMask;
      logic [RSC_NSRC-1:0]    prev;
      logic [RSC_HOLD_W-1:0]  holdCnt;
      logic                   master_system_reset;
      logic                   wdtEn;
      logic                   irqOut;
      logic                   ack;
      logic [31:0]            rdata;
      logic                   nvWdt;
      logic [1:0]             strapWait;
   } rsc_state_t;

   rsc_state_t st_r;
   rsc_state_t st_nxt;

   logic [2:0]           asyncSync;
   logic [RSC_NSRC-1:0]  src;
   logic [RSC_NSRC-1:0]  rise;
   logic                 anySrc;
   logic                 busReq;
   logic                 wrCause;
   logic                 wrMask;
   logic                 wrStat;
   logic [15:0]          wrMask16;

   // ----------------------------------------------------------------
   // synchronise the asynchronous levels
   // ----------------------------------------------------------------
   // order: {ext pin, strap, brown-out}; power-on is handled separately
   logic       porSync;

   rsc_sync #(
      .W    (3),
      .INIT (RSC_SYNC_INIT)
   ) u_sync_async (
      .clk  (clk),
      .nrst (nrst),
      .din  ({externalClearPinN, nvWatchdogEnable, brownOutReq}),
      .dout (asyncSync)
   );

   rsc_sync #(
      .W    (1),
      .INIT (1'h0)
   ) u_sync_por (
      .clk  (clk),
      .nrst (nrst),
      .din  (powerOnReq),
      .dout (porSync)
   );

   // ----------------------------------------------------------------
   // source vector and edge detection
   // ----------------------------------------------------------------
   // one bit per reset type, in flag order
   always_comb begin
      src               = '0;
      src[RSC_BIT_POR]  = porSync;
      src[RSC_BIT_BOR]  = asyncSync[0];
      src[RSC_BIT_EXT]  = ~asyncSync[2];
      src[RSC_BIT_SW]   = softwareResetReq;
      src[RSC_BIT_WDT]  = watchdogTimeoutReq;
      src[RSC_BIT_CM]   = configMismatchReq;
      src[RSC_BIT_TRAP] = trapConflictReq;
      src[RSC_BIT_ILL]  = illegalCondReq;
   end

   // a cause is caught on the first active cycle of its source
   assign rise   = src & ~st_r.prev;
   assign anySrc = |src;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   assign busReq   = cyc_i && stb_i && !st_r.ack;
   assign wrCause  = busReq && we_i && (adr_i == RSC_ADR_CAUSE);
   assign wrMask   = busReq && we_i && (adr_i == RSC_ADR_IRQMASK);
   assign wrStat   = busReq && we_i && (adr_i == RSC_ADR_IRQSTAT);
   assign wrMask16 = {{8{sel_i[1]}}, {8{sel_i[0]}}};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt      = st_r;
      st_nxt.prev = src;
      st_nxt.ack  = busReq;

      // software writes are plain status updates, no reset path
      if (wrCause) begin
         st_nxt.cause = (st_r.cause & ~wrMask16) | (dat_i[15:0] & wrMask16);
      end
      if (wrMask && sel_i[0]) begin
         st_nxt.irqMask = dat_i[7:0];
      end

      // interrupt status: write one to clear, a new event wins
      if (wrStat && sel_i[0]) begin
         st_nxt.irqStat = st_r.irqStat & ~dat_i[7:0];
      end
      st_nxt.irqStat = st_nxt.irqStat | rise;

      // hardware sets the cause flag of each new reset, over any write
      st_nxt.cause[RSC_NSRC-1:0] = st_nxt.cause[RSC_NSRC-1:0] | rise;

      // power-on leaves only its own flag and clears the watchdog bit as well
      if (src[RSC_BIT_POR]) begin
         st_nxt.cause = RSC_CAUSE_POR;
      end

      // hold the master reset until all sources end plus the hold time
      if (anySrc) begin
         st_nxt.holdCnt = RSC_HOLD_W'(HOLD_CYC);
      end else if (st_r.holdCnt != '0) begin
         st_nxt.holdCnt = st_r.holdCnt - RSC_HOLD_W'(1);
      end
      st_nxt.master_system_reset = anySrc || (st_r.holdCnt > RSC_HOLD_W'(1));

      // master reset forces the mask and soft enable, flags are kept
      if (st_r.master_system_reset) begin
         st_nxt.irqMask                 = RSC_MASK_RST;
         st_nxt.cause[RSC_BIT_SWDT]     = 1'b0;
      end

      // strap is sampled while the synchroniser refills after nrst;
      // its first outputs are the reset value, only the last sample counts
      if (st_r.strapWait != RSC_STRAP_CYC) begin
         st_nxt.nvWdt     = asyncSync[1];
         st_nxt.strapWait = st_r.strapWait + 2'h1;
      end

      // nonvolatile enable overrides the soft enable
      st_nxt.wdtEn  = st_nxt.nvWdt || st_nxt.cause[RSC_BIT_SWDT];
      st_nxt.irqOut = |(st_nxt.irqStat & st_nxt.irqMask);

      // read data, unmapped addresses read zero
      st_nxt.rdata = '0;
      if (busReq && !we_i) begin
         case (adr_i)
            RSC_ADR_CAUSE:   st_nxt.rdata = {16'h0000, st_r.cause};
            RSC_ADR_IRQMASK: st_nxt.rdata = {24'h000000, st_r.irqMask};
            RSC_ADR_IRQSTAT: st_nxt.rdata = {24'h000000, st_r.irqStat};
            default:         st_nxt.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r            <= '0;
         st_r.cause      <= RSC_CAUSE_POR;
         st_r.irqMask    <= RSC_MASK_RST;
         st_r.master_system_reset     <= 1'b1;
         st_r.holdCnt    <= RSC_HOLD_W'(HOLD_CYC);
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs straight from the state register
   // ----------------------------------------------------------------
   assign dat_o             = st_r.rdata;
   assign ack_o             = st_r.ack;
   assign masterSystemReset = st_r.master_system_reset;
   assign watchdogEnable    = st_r.wdtEn;
   assign irq               = st_r.irqOut;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // last cycle after a source ends at which the reset must still stand
   localparam int HOLD_LAST = HOLD_CYC - 1;

   sequence srcEnds;
      anySrc ##1 !anySrc;
   endsequence

   sequence holdsReset;
      ##HOLD_LAST masterSystemReset;
   endsequence

   property resetFollowsSource;
      anySrc |=> masterSystemReset;
   endproperty

   chk_reset_on_source: assert property (resetFollowsSource)
      else $error("master reset not raised by an active source");

   chk_reset_held_after: assert property (srcEnds |-> holdsReset)
      else $error("master reset released too early");

   chk_sw_source_reset: assert property (softwareResetReq |=> masterSystemReset)
      else $error("software reset did not assert master reset");

   chk_cause_flag_set: assert property (
      (|rise && !src[RSC_BIT_POR]) |=> ((st_r.cause[RSC_NSRC-1:0] & $past(rise)) == $past(rise))
   )
      else $error("reset cause flag not set");

   chk_por_only_flag: assert property (src[RSC_BIT_POR] |=> st_r.cause == RSC_CAUSE_POR)
      else $error("power-on did not leave only its own flag");

   chk_write_no_reset: assert property (
      (wrCause && !anySrc && st_r.holdCnt == '0) |=> !masterSystemReset [*2]
   )
      else $error("flag write caused a reset");

   chk_brownout_bit: assert property (
      (rise[RSC_BIT_BOR] && !src[RSC_BIT_POR]) |=> st_r.cause[RSC_BIT_BOR]
   )
      else $error("brown-out flag not set");

   chk_poweron_bit: assert property (rise[RSC_BIT_POR] |=> st_r.cause[RSC_BIT_POR])
      else $error("power-on flag not set");

   chk_subset_forced: assert property (
      masterSystemReset |=> (st_r.irqMask == RSC_MASK_RST && !st_r.cause[RSC_BIT_SWDT])
   )
      else $error("reset subset not forced");

   chk_nv_wdt_forced: assert property (st_r.nvWdt |=> watchdogEnable)
      else $error("watchdog not kept on by nonvolatile enable");

   chk_bus_ack_once: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
      else $error("bus ack not a single cycle");

   // a flag write with no reset source active, per byte lane
   sequence quietLowWrite;
      wrCause && sel_i[0] && !anySrc;
   endsequence

   sequence quietHighWrite;
      wrCause && sel_i[1] && !anySrc && !st_r.master_system_reset;
   endsequence

   // a read request taken at this edge
   sequence readTaken;
      busReq && !we_i;
   endsequence

   chk_flag_low_write: assert property (
      quietLowWrite |=> st_r.cause[7:0] == $past(dat_i[7:0])
   ) else $error("low flag byte does not hold the written value");

   chk_flag_high_write: assert property (
      quietHighWrite |=> st_r.cause[15:8] == $past(dat_i[15:8])
   ) else $error("high flag byte does not hold the written value");

   chk_event_status_set: assert property (
      |rise |=> (st_r.irqStat & $past(rise)) == $past(rise)
   ) else $error("event status not set by a new reset");

   chk_por_drops_bor: assert property (
      src[RSC_BIT_POR] |=> !st_r.cause[RSC_BIT_BOR]
   ) else $error("brown-out flag survived a power-on");

   chk_ext_pin_reset: assert property (
      src[RSC_BIT_EXT] |=> masterSystemReset
   ) else $error("external clear pin did not assert master reset");

   chk_irq_raised: assert property (
      (|(st_r.irqStat & st_r.irqMask) && !wrStat && !wrMask && !st_r.master_system_reset) |=> irq
   ) else $error("interrupt low with an unmasked event");

   chk_irq_quiet: assert property (
      (!(|rise) && !wrMask && (st_r.irqStat & st_r.irqMask) == '0) |=> !irq
   ) else $error("interrupt high with no unmasked event");

   chk_read_cause: assert property (
      (readTaken ##0 (adr_i == RSC_ADR_CAUSE)) |=> dat_o == {16'h0000, $past(st_r.cause)}
   ) else $error("cause read returned a wrong value");

   chk_read_idle_zero: assert property (
      !(busReq && !we_i) |=> dat_o == 32'h0000_0000
   ) else $error("read data not zero outside a read answer");

   chk_ack_needs_req: assert property (
      !(cyc_i && stb_i) |=> !ack_o
   ) else $error("ack without a bus request");

   chk_soft_wdt_on: assert property (
      (st_r.cause[RSC_BIT_SWDT] && !st_r.master_system_reset && !wrCause && !anySrc) |=> watchdogEnable
   ) else $error("soft watchdog enable ignored");

endmodule
`default_nettype wire

// File: src/rsc_sync.sv
// two flip-flop synchroniser for asynchronous level inputs.
// assumes the inputs are quasi-static levels; no pulse shorter than
// one clock period is guaranteed to pass.
`timescale 1ns/1ps
`default_nettype none
module rsc_sync
   import rsc_pkg::*;
#(
   parameter int            W    = 3,
   parameter logic [W-1:0]  INIT = '0
) (
   input  wire logic          clk,   // system clock
   input  wire logic          nrst,  // synchronous reset, active low
   input  wire logic [W-1:0]  din,   // asynchronous levels
   output logic      [W-1:0]  dout   // synchronised levels
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } rsc_sync_t;

   rsc_sync_t st_r;
   rsc_sync_t st_nxt;

   // ----------------------------------------------------------------
   // two stages per bit, first stage feeds only the second
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= {INIT, INIT};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.s2;

endmodule
`default_nettype wire

// File: test/reset_source_combiner_tb_top.sv
// self-checking bench for the reset source combiner: register access,
// every reset source, hold time, interrupt and watchdog enable.
// assumes a shortened hold parameter; every bus wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module reset_source_combiner_tb_top
   import rsc_pkg::*;
();
   // ----------------------------------------------------------------
   // signals and design instance
   // ----------------------------------------------------------------
   localparam int HOLD = 3;            // short master reset hold
   logic        clk;
   logic        nrst;
   logic        powerOnReq;
   logic        brownOutReq;
   logic        extClearPinN;
   logic [4:0]  srcVec;                // software, watchdog, mismatch, trap, illegal
   logic        nvWdEn;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [31:0] datW;
   logic [31:0] datR;
   logic        ack;
   logic        mstRst;
   logic        wdEn;
   logic        irq;
   int          mismatches;
   int          checked;

   reset_source_combiner #(.HOLD_CYC(HOLD)) u_reset_source_combiner (
      .clk(clk), .nrst(nrst), .powerOnReq(powerOnReq), .brownOutReq(brownOutReq),
      .externalClearPinN(extClearPinN), .softwareResetReq(srcVec[0]),
      .watchdogTimeoutReq(srcVec[1]), .configMismatchReq(srcVec[2]),
      .trapConflictReq(srcVec[3]), .illegalCondReq(srcVec[4]),
      .nvWatchdogEnable(nvWdEn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .dat_i(datW), .sel_i(4'hF), .dat_o(datR), .ack_o(ack),
      .masterSystemReset(mstRst), .watchdogEnable(wdEn), .irq(irq));

   // clock generation, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one classic cycle: hold the request until ack is sampled high
   task automatic wbAccess(input logic wr, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= wr;
      adr  <= a;
      datW <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      check("bus answer", 32'h1, {31'h0, ack});
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wbWrite(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wbAccess(1'b1, a, d, q);
   endtask

   task automatic wbRead(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      wbAccess(1'b0, a, 32'h0, q);
      check(what, exp, q);
   endtask

   // bounded wait for the master reset to drop
   task automatic waitRelease();
      int n;
      n = 0;
      @(posedge clk);
      while (mstRst !== 1'b0 && n < 60) begin
         @(posedge clk);
         n++;
      end
      check("reset release", 32'h0, {31'h0, mstRst});
   endtask

   task automatic applyNrst(input logic strap);
      nvWdEn <= strap;
      nrst   <= 1'b0;
      repeat (6) @(posedge clk);
      check("reset during nrst", 32'h1, {31'h0, mstRst});
      nrst <= 1'b1;
      waitRelease();
      wbRead(RSC_ADR_CAUSE, 32'h0000_0001, "cause after power-on");
      check("watchdog enable", {31'h0, strap}, {31'h0, wdEn});
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      int n;
      nrst = 1'b0; powerOnReq = 1'b0; brownOutReq = 1'b0; extClearPinN = 1'b1;
      srcVec = 5'h00; nvWdEn = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
      adr = 8'h00; datW = 32'h0; mismatches = 0; checked = 0;
      applyNrst(1'b1);
      // flag writes are status only
      wbWrite(RSC_ADR_CAUSE, 32'h0000_00FE);
      repeat (2) @(posedge clk);
      check("reset after flag write", 32'h0, {31'h0, mstRst});
      wbRead(RSC_ADR_CAUSE, 32'h0000_00FE, "cause set by software");
      check("watchdog forced on", 32'h1, {31'h0, wdEn});
      wbRead(8'h40, 32'h0, "unmapped read");
      $display("test register access done");
      // same-clock sources: one-cycle pulse, exact hold, own flag
      for (int i = 0; i < 5; i++) begin
         wbWrite(RSC_ADR_CAUSE, 32'h0);
         @(posedge clk);
         srcVec[i] <= 1'b1;
         @(posedge clk);
         srcVec[i] <= 1'b0;
         n = 0;
         @(posedge clk);
         while (mstRst === 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
         end
         check("reset hold cycles", HOLD, n);
         wbRead(RSC_ADR_CAUSE, 32'h1 << (i + 3), "cause flag");
         wbRead(RSC_ADR_IRQSTAT, 32'h1 << (i + 3), "event status");
         wbWrite(RSC_ADR_IRQSTAT, 32'h0000_00FF);
      end
      // asynchronous level sources held for several cycles
      for (int i = 1; i < 3; i++) begin
         wbWrite(RSC_ADR_CAUSE, 32'h0);
         @(posedge clk);
         brownOutReq  <= (i == 1);
         extClearPinN <= (i != 2);
         repeat (8) @(posedge clk);
         check("reset while source held", 32'h1, {31'h0, mstRst});
         brownOutReq  <= 1'b0;
         extClearPinN <= 1'b1;
         repeat (2) @(posedge clk);
         check("reset after source ends", 32'h1, {31'h0, mstRst});
         waitRelease();
         wbRead(RSC_ADR_CAUSE, 32'h1 << i, "async cause flag");
         wbWrite(RSC_ADR_IRQSTAT, 32'h0000_00FF);
      end
      $display("test reset sources done");
      // master reset clears the mask; status survives and raises irq
      wbWrite(RSC_ADR_IRQMASK, 32'h0000_00FF);
      wbRead(RSC_ADR_IRQMASK, 32'h0000_00FF, "mask written");
      @(posedge clk);
      srcVec[0] <= 1'b1;
      @(posedge clk);
      srcVec[0] <= 1'b0;
      waitRelease();
      wbRead(RSC_ADR_IRQMASK, 32'h0, "mask after master reset");
      check("irq while masked", 32'h0, {31'h0, irq});
      wbWrite(RSC_ADR_IRQMASK, 32'h0000_0008);
      repeat (2) @(posedge clk);
      check("irq unmasked", 32'h1, {31'h0, irq});
      wbWrite(RSC_ADR_IRQSTAT, 32'h0000_0008);
      repeat (2) @(posedge clk);
      check("irq after clear", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      // power-on input wipes the other flags
      wbWrite(RSC_ADR_CAUSE, 32'h0000_00FE);
      @(posedge clk);
      powerOnReq <= 1'b1;
      repeat (4) @(posedge clk);
      powerOnReq <= 1'b0;
      waitRelease();
      wbRead(RSC_ADR_CAUSE, 32'h0000_0001, "cause after power-on input");
      // strap low: soft enable decides
      applyNrst(1'b0);
      wbWrite(RSC_ADR_CAUSE, 32'h0000_0100);
      repeat (2) @(posedge clk);
      check("soft watchdog enable", 32'h1, {31'h0, wdEn});
      $display("test power-on and watchdog done");
      end_sim();
   end

   // watchdog against a hung run
   initial begin
      #400000;
      mismatches++;
      $display("[ERR] run time expected below limit seen limit reached");
      end_sim();
   end
endmodule
`default_nettype wire
